// >>> ext_mem_model.sv
`timescale 1ns/1ps
// =====================================
// far-side memory stub, one access per start pulse
module ext_mem_model (
    input wire logic clk,
    input wire logic resetn,
    input wire logic start,
    input wire logic [1:0] mode,
    input wire logic rd,
    input wire logic [3:0] pins,
    input wire logic [7:0] len,
    output logic access_req,
    output logic [1:0] access_addr_mode,
    output logic async_strobe_active,
    output logic async_read_active,
    output logic write_active,
    output logic access_active,
    output logic [3:0] ext_wait_inputs
);
    logic [7:0] left; // strobe cycles still to run
    // request pulse and strobe length
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            left <= 8'h00;
            access_req <= 1'b0;
            access_addr_mode <= 2'h0;
        end else begin
            access_req <= start;
            access_addr_mode <= start ? mode : 2'h0;
            left <= start ? len : (left != 8'h00 ? left - 8'h01 : 8'h00);
        end
    end
    assign access_active = left != 8'h00;
    assign async_strobe_active = access_active;
    assign async_read_active = access_active && rd;
    assign write_active = access_active && !rd;
    // wait lines have pull-downs, so they sit low between strobes
    assign ext_wait_inputs = access_active ? pins : 4'h0;
endmodule

// >>> extmem_interrupt_and_power_ctrl.sv
`timescale 1ns/1ps
module extmem_interrupt_and_power_ctrl (
    input wire logic clk,
    input wire logic resetn,
    // axi4-lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // external wait pins
    input wire logic [3:0] ext_wait_inputs,
    // access engine status, same clock
    input wire logic access_req,
    input wire logic [1:0] access_addr_mode,
    input wire logic async_strobe_active,
    input wire logic async_read_active,
    input wire logic sdram_read_active,
    input wire logic write_active,
    input wire logic access_active,
    input wire logic self_refresh,
    input wire logic power_down,
    // outputs to engines and pins
    output logic [1:0] exec_addr_mode,
    output logic mem_clk_tick,
    output logic sdram_clock_en,
    output logic data_bus_oe_n,
    output logic power_down_return,
    output logic irq
);
    // =====================================================
    // state declarations
    extmem_irq_pkg::irq_bits_type raw; // raw status
    extmem_irq_pkg::irq_bits_type masked; // masked status
    extmem_irq_pkg::irq_bits_type enable; // interrupt enables
    extmem_irq_pkg::irq_bits_type event_now; // this cycle's events
    extmem_irq_pkg::ctrl_type ctrl; // control register
    logic [3:0] wait_level; // synchronised pins
    logic [3:0] wait_rise; // edge pulses
    logic [7:0] wait_count; // cycles wait held
    logic timeout_fired; // one event per wait period
    logic timeout_hit; // timeout this cycle
    logic trap_hit; // unsupported mode this cycle
    logic half_phase; // divider phase
    logic read_was; // async read seen last cycle
    logic bus_float; // bus left undriven
    logic access_was; // access seen last cycle
    // bus slave state
    logic aw_held;
    logic w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic do_write;
    logic [15:0] wmask;
    logic [15:0] wbits;
    // =====================================================
    // helpers
    // byte lanes to bit mask, only low two lanes hold bits
    function automatic logic [15:0] lane_mask(input logic [3:0] strb);
        lane_mask = {{8{strb[1]}}, {8{strb[0]}}};
    endfunction

    // register hit on word address, low two bits ignored
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a[7:2] == off[7:2]);
    endfunction
    // =====================================================
    // wait pin synchroniser and edge detector
    wait_sync_edge #(
        .WIDTH(4)
    ) u_wait (
        .clk(clk),
        .resetn(resetn),
        .pin_in(ext_wait_inputs),
        .level(wait_level),
        .rise(wait_rise)
    );
    // =====================================================
    // event sources
    // edge on raw level, polarity not applied
    assign event_now.wr = wait_rise;
    assign event_now.at = timeout_hit;
    assign event_now.trap = trap_hit;
    // any mode other than linear counts as a trap
    assign trap_hit = access_req && (access_addr_mode != extmem_irq_pkg::LINEAR_MODE);
    // wait counter, polarity picks the asserted level
    logic wait_on;
    assign wait_on = |(wait_level ~^ ctrl.wait_polarity_bits);
    assign timeout_hit = async_strobe_active && wait_on && !timeout_fired
        && (wait_count >= ctrl.max_wait_cycles);
    // count while an async strobe is stretched by wait
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wait_count <= 8'h00;
            timeout_fired <= 1'b0;
        end else if (async_strobe_active && wait_on) begin
            // saturate so a stuck pin cannot wrap
            if (wait_count != 8'hFF) begin
                wait_count <= wait_count + 8'h01;
            end
            if (timeout_hit) begin
                timeout_fired <= 1'b1;
            end
        end else begin
            wait_count <= 8'h00;
            timeout_fired <= 1'b0;
        end
    end
    // trapped requests still run as linear increments
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            exec_addr_mode <= extmem_irq_pkg::LINEAR_MODE;
        end else begin
            exec_addr_mode <= extmem_irq_pkg::LINEAR_MODE;
        end
    end
    // =====================================================
    // axi4-lite write channel
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign do_write = aw_held && w_held && !s_axi_bvalid;
    assign wmask = lane_mask(w_strb);
    assign wbits = w_data[15:0] & wmask;
    // address and data taken in either order
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            aw_held <= 1'b0;
            aw_addr <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end else if (do_write) begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            w_held <= 1'b0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end else if (do_write) begin
            w_held <= 1'b0;
        end
    end
    // response, slave error for unmapped words
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= extmem_irq_pkg::RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            if (aw_addr > extmem_irq_pkg::STATUS_OFFSET + 8'h03) begin
                s_axi_bresp <= extmem_irq_pkg::RESP_SLVERR;
            end else begin
                s_axi_bresp <= extmem_irq_pkg::RESP_OKAY;
            end
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end
    // =====================================================
    // register write decode
    logic [5:0] raw_clr; // write-one-to-clear bits
    logic [5:0] en_set; // write-one-to-set bits
    logic [5:0] en_clr; // write-one-to-clear enables
    assign raw_clr = (do_write && hit(aw_addr, extmem_irq_pkg::RAW_OFFSET))
        ? wbits[5:0] : 6'h00;
    assign en_set = (do_write && hit(aw_addr, extmem_irq_pkg::EN_SET_OFFSET))
        ? wbits[5:0] : 6'h00;
    assign en_clr = (do_write && hit(aw_addr, extmem_irq_pkg::EN_CLR_OFFSET))
        ? wbits[5:0] : 6'h00;
    // raw status, set beats clear in the same cycle
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            raw <= extmem_irq_pkg::EVENT_RESET;
        end else begin
            raw <= (raw & ~raw_clr) | event_now;
        end
    end
    // masked status, only enabled events land here
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            masked <= extmem_irq_pkg::EVENT_RESET;
        end else begin
            masked <= (masked & ~raw_clr) | (event_now & enable);
        end
    end
    // enables, a clear written with a set wins
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            enable <= extmem_irq_pkg::EVENT_RESET;
        end else begin
            enable <= (enable | en_set) & ~en_clr;
        end
    end
    // control register, byte lanes honoured
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ctrl <= extmem_irq_pkg::CTRL_RESET;
        end else if (do_write && hit(aw_addr, extmem_irq_pkg::CTRL_OFFSET)) begin
            ctrl <= (ctrl & ~wmask) | wbits;
        end
    end
    // =====================================================
    // axi4-lite read channel, one cycle latency
    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= extmem_irq_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= extmem_irq_pkg::RESP_OKAY;
            case (s_axi_araddr[7:2])
                extmem_irq_pkg::RAW_OFFSET[7:2]: begin
                    s_axi_rdata <= {26'h0, raw};
                end
                extmem_irq_pkg::MASKED_OFFSET[7:2]: begin
                    s_axi_rdata <= {26'h0, masked};
                end
                // both enable views show the live state
                extmem_irq_pkg::EN_SET_OFFSET[7:2],
                extmem_irq_pkg::EN_CLR_OFFSET[7:2]: begin
                    s_axi_rdata <= {26'h0, enable};
                end
                extmem_irq_pkg::CTRL_OFFSET[7:2]: begin
                    s_axi_rdata <= {16'h0, ctrl};
                end
                extmem_irq_pkg::STATUS_OFFSET[7:2]: begin
                    s_axi_rdata <= {22'h0, bus_float, power_down, self_refresh,
                        timeout_fired, wait_level, 2'h0};
                end
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= extmem_irq_pkg::RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
    // =====================================================
    // interrupt output, no dma event path exists
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            irq <= 1'b0;
        end else begin
            // dedicated line, held until raw bits cleared
            irq <= |((masked & ~raw_clr) | (event_now & enable));
        end
    end
    // =====================================================
    // memory clock ratio and gating
    // a tick per cycle, or every second cycle in half mode
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            half_phase <= 1'b0;
            mem_clk_tick <= 1'b0;
        end else begin
            half_phase <= ctrl.clock_half_select ? ~half_phase : 1'b0;
            mem_clk_tick <= !ctrl.clock_half_select || half_phase;
        end
    end
    // stopped clock saves power when no sdram fitted
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sdram_clock_en <= 1'b0;
        end else begin
            sdram_clock_en <= ctrl.sdram_clock_on;
        end
    end
    // =====================================================
    // data bus parking
    // self-refresh gates nothing above; only parking changes
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            read_was <= 1'b0;
            bus_float <= 1'b0;
        end else begin
            read_was <= async_read_active;
            if (write_active) begin
                bus_float <= 1'b0;
            end else if (read_was && !async_read_active && self_refresh) begin
                bus_float <= 1'b1;
            end
        end
    end
    // oe low while parked, high during reads or float
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            data_bus_oe_n <= 1'b1;
        end else begin
            data_bus_oe_n <= async_read_active || sdram_read_active
                || bus_float || (read_was && self_refresh);
        end
    end

    // =====================================================
    // power-down return after each access
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            access_was <= 1'b0;
            power_down_return <= 1'b0;
        end else begin
            access_was <= access_active;
            power_down_return <= access_was && !access_active && power_down;
        end
    end
    // no halt input: logic runs on through emulation stops

    // =====================================================
    // assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence rise_seen(int i);
        wait_rise[i] && raw_clr == 6'h00;
    endsequence

    wait_raw_set_a: assert property (rise_seen(0) |=> raw.wr[0])
        else $error("wait rise did not set raw bit");
    trap_raw_set_a: assert property (trap_hit |=> raw.trap)
        else $error("line trap did not set raw bit");
    masked_gate_a: assert property ($rose(masked.at) |-> $past(enable.at))
        else $error("masked bit set while disabled");
    raw_clear_a: assert property (
        raw_clr[4] && !event_now.at |=> !raw.at && !masked.at)
        else $error("write one did not clear raw and masked");
    enable_set_a: assert property (en_set[5] && !en_clr[5] |=> enable.trap)
        else $error("enable set failed");
    enable_clr_a: assert property (en_clr[0] |=> !enable.wr[0])
        else $error("enable clear failed");
    irq_or_a: assert property (irq == |masked)
        else $error("interrupt not or of masked bits");
    half_tick_a: assert property (
        ctrl.clock_half_select [*4] |-> ##1 (mem_clk_tick != $past(mem_clk_tick)))
        else $error("half rate tick did not alternate");
    timeout_once_a: assert property (timeout_hit |=> !timeout_hit)
        else $error("timeout raised twice in one wait");
    float_read_a: assert property (
        read_was && !async_read_active && self_refresh && !write_active
        |=> bus_float ##1 data_bus_oe_n)
        else $error("bus parked after self-refresh read");
    pd_return_a: assert property (
        $fell(access_active) && power_down |=> power_down_return)
        else $error("no return to power-down");
endmodule

// >>> extmem_irq_pkg.sv
// Summary of operation
// - wait pin rise sets its raw bit
// - wait event ignores wait polarity bits
// - wait held past maximum raises timeout
// - non-linear request sets trap, runs linear
// - raw bits set whether enabled or not
// - masked bits set only when enabled
// - write one to raw clears raw and masked
// - enable-set write of one enables
// - enable-clear write of one disables
// - both enable registers read enable state
// - one dedicated interrupt, enabled sources only
// - no dma request events produced
// - select bit halves memory clock rate
// - sdram clock can be stopped
// - self-refresh keeps other accesses serviced
// - async read in self-refresh floats bus
// - power-down returns after each access
// - fully operational during emulation halt
// - reset clears state and queued work
package extmem_irq_pkg;
    // =====================================================
    // register byte offsets
    localparam logic [7:0] RAW_OFFSET = 8'h00;
    localparam logic [7:0] MASKED_OFFSET = 8'h04;
    localparam logic [7:0] EN_SET_OFFSET = 8'h08;
    localparam logic [7:0] EN_CLR_OFFSET = 8'h0C;
    localparam logic [7:0] CTRL_OFFSET = 8'h10;
    localparam logic [7:0] STATUS_OFFSET = 8'h14;
    // =====================================================
    // event field positions
    localparam int WR_LSB = 0;
    localparam int AT_BIT = 4;
    localparam int TRAP_BIT = 5;
    localparam int EVENT_BITS = 6;
    // =====================================================
    // control field positions
    localparam int HALF_BIT = 0;
    localparam int SDRAM_CLK_ON_BIT = 1;
    localparam int POL_LSB = 4;
    localparam int MAX_WAIT_LSB = 8;
    // control reset: full rate, clock stopped, max wait 0xFF
    localparam logic [15:0] CTRL_RESET = 16'hFF00;
    localparam logic [5:0] EVENT_RESET = 6'h00;
    // =====================================================
    // addressing and bus answers
    localparam logic [1:0] LINEAR_MODE = 2'h0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // =====================================================
    // carriers
    typedef struct packed {
        logic trap;
        logic at;
        logic [3:0] wr;
    } irq_bits_type;
    typedef struct packed {
        logic [7:0] max_wait_cycles;
        logic [3:0] wait_polarity_bits;
        logic [1:0] spare;
        logic sdram_clock_on;
        logic clock_half_select;
    } ctrl_type;
endpackage

// >>> test_extmem_interrupt_and_power_ctrl.sv
`timescale 1ns/1ps
module test_extmem_interrupt_and_power_ctrl;
    // =====================================
    // signals
    localparam logic [7:0] RAW = extmem_irq_pkg::RAW_OFFSET;
    localparam logic [7:0] MSK = extmem_irq_pkg::MASKED_OFFSET;
    localparam logic [7:0] SET = extmem_irq_pkg::EN_SET_OFFSET;
    localparam logic [7:0] CLR = extmem_irq_pkg::EN_CLR_OFFSET;
    localparam logic [7:0] CTL = extmem_irq_pkg::CTRL_OFFSET;
    // rows: enables in [9:4], kind in [3:0]: 0..3 wait pin, 4..6 trap mode 1..3
    localparam logic [9:0] ROWS [7] = '{10'h3F0, 10'h001, 10'h042, 10'h373,
        10'h204, 10'h005, 10'h1F6};
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, len = 8'h06;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, data, ticks;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, start = 1'b0, rd = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, access_addr_mode, exec_addr_mode, resp;
    logic [1:0] mode = 2'h0;
    logic [3:0] ext_wait_inputs, pins = 4'h0;
    logic access_req, async_strobe_active, async_read_active, write_active, access_active;
    logic self_refresh = 1'b0, power_down = 1'b0;
    logic mem_clk_tick, sdram_clock_en, data_bus_oe_n, power_down_return, irq;
    logic [5:0] er, en;
    int failures = 0, samples_checked = 0, cycles = 0;
    always #20 clk = ~clk;
    extmem_interrupt_and_power_ctrl dut (.clk, .resetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .ext_wait_inputs, .access_req, .access_addr_mode, .async_strobe_active,
        .async_read_active, .sdram_read_active(1'b0), .write_active, .access_active,
        .self_refresh, .power_down, .exec_addr_mode, .mem_clk_tick, .sdram_clock_en,
        .data_bus_oe_n, .power_down_return, .irq);
    ext_mem_model mem (.clk, .resetn, .start, .mode, .rd, .pins, .len, .access_req,
        .access_addr_mode, .async_strobe_active, .async_read_active, .write_active,
        .access_active, .ext_wait_inputs);
    // =====================================
    // helpers; handshakes sampled at the falling edge, acted on at the next rise
    task automatic give_verdict();
        if (failures == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ta, tw, tb;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (int n = 0; n < 30; n++) begin
            @(negedge clk);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            tb = s_axi_bvalid;
            resp = s_axi_bresp;
            @(posedge clk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
            if (tb) begin
                s_axi_bready <= 1'b0;
                n = 30;
            end
        end
    endtask
    task automatic rd_reg(input logic [7:0] a);
        logic ta, tr;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (int n = 0; n < 30; n++) begin
            @(negedge clk);
            ta = s_axi_arvalid && s_axi_arready;
            tr = s_axi_rvalid;
            data = s_axi_rdata;
            resp = s_axi_rresp;
            @(posedge clk);
            if (ta) s_axi_arvalid <= 1'b0;
            if (tr) begin
                s_axi_rready <= 1'b0;
                n = 30;
            end
        end
    endtask
    task automatic fire(input logic [1:0] m, input logic [3:0] p, input logic r);
        @(posedge clk);
        start <= 1'b1;
        mode <= m;
        pins <= p;
        rd <= r;
        @(posedge clk);
        start <= 1'b0;
    endtask
    task automatic count_ticks();
        ticks = 32'h0;
        repeat (8) begin
            @(negedge clk);
            ticks = ticks + {31'h0, mem_clk_tick};
        end
    endtask
    // hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            give_verdict();
        end
    end
    // =====================================
    // main sequence
    initial begin
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        rd_reg(CTL);
        chk(data, 32'h0000FF00);
        rd_reg(SET);
        chk(data, 32'h0);
        // clock setup before enables, as software must
        wr(CTL, 32'h0000FFF3);
        chk({30'h0, resp}, 32'h0);
        count_ticks();
        chk(ticks, 32'h4);
        chk({31'h0, sdram_clock_en}, 32'h1);
        wr(CTL, 32'h0000FF00);
        count_ticks();
        chk(ticks, 32'h8);
        chk({31'h0, sdram_clock_en}, 32'h0);
        wr(SET, 32'h15);
        wr(SET, 32'h0);
        rd_reg(SET);
        chk(data, 32'h15);
        rd_reg(CLR);
        chk(data, 32'h15);
        wr(CLR, 32'h05);
        rd_reg(SET);
        chk(data, 32'h10);
        rd_reg(CLR);
        chk(data, 32'h10);
        // polarity bits all zero here, so a rising pin is not a wait assertion
        foreach (ROWS[i]) begin
            er = ROWS[i][3:0] < 4'h4 ? 6'h01 << ROWS[i][3:0] : 6'h20;
            en = ROWS[i][9:4];
            wr(CLR, 32'h3F);
            wr(SET, {26'h0, en});
            fire(ROWS[i][3:0] < 4'h4 ? 2'h0 : 2'(ROWS[i][3:0] - 4'h3), er[3:0], 1'b0);
            repeat (8) @(posedge clk);
            rd_reg(RAW);
            chk(data, {26'h0, er});
            rd_reg(MSK);
            chk(data, {26'h0, er & en});
            chk({31'h0, irq}, {31'h0, |(er & en)});
            chk({30'h0, exec_addr_mode}, 32'h0);
            wr(RAW, 32'h0);
            rd_reg(RAW);
            chk(data, {26'h0, er});
            wr(RAW, 32'h3F);
            rd_reg(MSK);
            chk(data, 32'h0);
            chk({31'h0, irq}, 32'h0);
        end
        wr(8'h18, 32'hFFFF);
        chk({30'h0, resp}, {30'h0, extmem_irq_pkg::RESP_SLVERR});
        rd_reg(8'h18);
        chk(data, 32'h0);
        chk({30'h0, resp}, {30'h0, extmem_irq_pkg::RESP_SLVERR});
        // wait held high past a short maximum of four cycles
        wr(CTL, 32'h000004F0);
        wr(CLR, 32'h3F);
        wr(SET, 32'h10);
        len <= 8'h0C;
        fire(2'h0, 4'h1, 1'b0);
        repeat (16) @(posedge clk);
        rd_reg(RAW);
        chk(data, 32'h11);
        rd_reg(MSK);
        chk(data, 32'h10);
        wr(RAW, 32'h3F);
        self_refresh <= 1'b1;
        len <= 8'h04;
        fire(2'h0, 4'h0, 1'b1);
        repeat (8) @(posedge clk);
        rd_reg(CTL);
        chk(data, 32'h000004F0);
        chk({31'h0, data_bus_oe_n}, 32'h1);
        fire(2'h0, 4'h0, 1'b0);
        repeat (8) @(negedge clk);
        chk({31'h0, data_bus_oe_n}, 32'h0);
        @(posedge clk);
        self_refresh <= 1'b0;
        power_down <= 1'b1;
        fire(2'h0, 4'h0, 1'b0);
        data = 32'h0;
        repeat (12) begin
            @(negedge clk);
            if (power_down_return === 1'b1) data = 32'h1;
        end
        chk(data, 32'h1);
        @(posedge clk);
        power_down <= 1'b0;
        // reset in mid-run with a pending interrupt
        wr(SET, 32'h3F);
        fire(2'h2, 4'h0, 1'b0);
        repeat (4) @(posedge clk);
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        @(negedge clk);
        chk({31'h0, irq}, 32'h0);
        rd_reg(RAW);
        chk(data, 32'h0);
        rd_reg(SET);
        chk(data, 32'h0);
        give_verdict();
    end
endmodule

// >>> wait_sync_edge.sv
`timescale 1ns/1ps
// two-flop synchroniser plus rising edge pulse per pin
module wait_sync_edge #(
    parameter int WIDTH = 4
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] level,
    output logic [WIDTH-1:0] rise
);
    // =====================================================
    // per pin stages
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : gen_pin
            logic meta; // first stage, read only by second
            logic sync; // second stage
            logic prev; // delayed copy for edge
            always_ff @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    meta <= 1'b0;
                    sync <= 1'b0;
                    prev <= 1'b0;
                end else begin
                    meta <= pin_in[g];
                    sync <= meta;
                    prev <= sync;
                end
            end
            assign level[g] = sync;
            // raw edge, no polarity applied
            assign rise[g] = sync & ~prev;
        end
    endgenerate
endmodule
